//--- logic/atten_mix_pkg.sv
// Package with register map, field layout, reset values and gain constants.
package atten_mix_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 16;
  localparam int          SAMPLE_W        = 16;
  localparam int          ATTEN_W         = 6;
  localparam logic [4:0]  ADDR_CONV_CTRL  = 5'h00;
  localparam logic [4:0]  ADDR_DAC2_ATTEN = 5'h0c;
  localparam logic [4:0]  ADDR_ADC_MIX    = 5'h0d;

  // ---------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------
  localparam int           LEFT_MUTE_BIT   = 15;
  localparam int           LEFT_ATTEN_LSB  = 8;
  localparam int           RIGHT_MUTE_BIT  = 7;
  localparam int           RIGHT_ATTEN_LSB = 0;
  localparam int           CONV_DIS_BIT    = 15;
  localparam logic [15:0]  WRITABLE_MASK   = 16'hbfbf;
  localparam logic [15:0]  DAC2_ATTEN_RST  = 16'h0000;
  localparam logic [15:0]  ADC_MIX_RST     = 16'h8080;
  localparam logic [15:0]  CONV_CTRL_RST   = 16'h0000;
  localparam logic [5:0]   ATTEN_FULL_MUTE = 6'h3f;

  // ---------------------------------------------------------------------
  // Gain arithmetic: 1.5 dB steps as a 2^(-1/4) mantissa times a shift
  // ---------------------------------------------------------------------
  localparam int ATTEN_SHIFT_PER = 4;

endpackage : atten_mix_pkg

//--- logic/atten_stage.sv
// Applies one six-bit 1.5 dB attenuation code and mute to a sample.
`timescale 1ns/100ps
module atten_stage
  import atten_mix_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic signed [W-1:0]  sample_in,
  input  wire logic [ATTEN_W-1:0]   atten,
  input  wire logic                 mute,
  input  wire logic                 full_mute_code,
  output logic signed [W-1:0]       sample_out
);

  // Fraction 2^(-k/4) in Q1.15 for the residue k of the step count.
  function automatic logic signed [17:0] step_frac(input logic [1:0] k);
    case (k)
      2'd0:    step_frac = 18'sh08000;
      2'd1:    step_frac = 18'sh06ba2;
      2'd2:    step_frac = 18'sh05a82;
      default: step_frac = 18'sh04c1c;
    endcase
  endfunction : step_frac

  // Fraction bits of the step mantissa, undone by the shift below.
  localparam int FRAC_BITS = 15;

  logic signed [W+17:0] prod;
  logic signed [W+17:0] shifted;

  // Every four steps is exactly 6 dB, so a shift handles the coarse part.
  always_comb begin
    prod    = sample_in * step_frac(atten[1:0]);
    shifted = prod >>> (FRAC_BITS + int'(atten[ATTEN_W-1:2]));
  end

  // Output is registered so the data path stays glitch free.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sample_out <= '0;
    end else if (mute || (full_mute_code && atten == ATTEN_FULL_MUTE)) begin
      sample_out <= '0;
    end else begin
      sample_out <= shifted[W-1:0];
    end
  end

endmodule : atten_stage

//--- logic/sat_adder.sv
// Saturating adder that joins the mix contribution into the DAC1 path.
`timescale 1ns/100ps
module sat_adder #(
  parameter int W = 16
) (
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic signed [W-1:0] a,
  input  wire logic signed [W-1:0] b,
  output logic signed [W-1:0]      sum
);

  logic signed [W:0] wide;

  // Clip instead of wrapping, since a wrap would be a loud click.
  always_comb begin
    wide = {a[W-1], a} + {b[W-1], b};
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sum <= '0;
    end else if (wide[W] != wide[W-1]) begin
      sum <= wide[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
    end else begin
      sum <= wide[W-1:0];
    end
  end

endmodule : sat_adder

//--- logic/dac_atten_adc_mix_regs.sv
// DAC2 attenuation and ADC-to-DAC1 mix registers with their data paths.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
module dac_atten_adc_mix_regs
  import atten_mix_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 power_down_pin_n,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [DATA_W-1:0]    reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [DATA_W-1:0]         reg_rdata,
  input  wire logic signed [W-1:0]  dac2_left_in,
  input  wire logic signed [W-1:0]  dac2_right_in,
  output logic signed [W-1:0]       dac2_left_out,
  output logic signed [W-1:0]       dac2_right_out,
  input  wire logic signed [W-1:0]  adc_left,
  input  wire logic signed [W-1:0]  adc_right,
  input  wire logic signed [W-1:0]  dac1_left_in,
  input  wire logic signed [W-1:0]  dac1_right_in,
  output logic signed [W-1:0]       dac1_left_out,
  output logic signed [W-1:0]       dac1_right_out,
  output logic                      all_conversions_disable,
  output logic                      regs_locked
);

  // ---------------------------------------------------------------------
  // Power-down pin synchroniser
  // ---------------------------------------------------------------------
  logic pd_meta_reg;
  logic pd_sync_reg;

  // The pin is asynchronous; two flops before anything looks at it.
  // Reset value is "powered down" so the lock holds until the pin is seen.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pd_meta_reg <= 1'b0;
      pd_sync_reg <= 1'b0;
    end else begin
      pd_meta_reg <= power_down_pin_n;
      pd_sync_reg <= pd_meta_reg;
    end
  end

  // ---------------------------------------------------------------------
  // Conversion control bit at address 0
  // ---------------------------------------------------------------------
  logic conv_dis_reg;

  // Only the disable bit is held here; the rest of address 0 lives elsewhere.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      conv_dis_reg <= CONV_CTRL_RST[CONV_DIS_BIT];
    end else if (reg_wr && reg_addr == ADDR_CONV_CTRL) begin
      conv_dis_reg <= reg_wdata[CONV_DIS_BIT];
    end
  end

  assign all_conversions_disable = conv_dis_reg;

  // Lock is combinational on the disable bit so it bites in the next cycle.
  assign regs_locked = !pd_sync_reg || conv_dis_reg;

  // ---------------------------------------------------------------------
  // Attenuation and mix registers
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] dac2_atten_reg;
  logic [DATA_W-1:0] adc_mix_reg;

  // Held at default while locked; a locked write is simply lost.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dac2_atten_reg <= DAC2_ATTEN_RST;
    end else if (regs_locked) begin
      dac2_atten_reg <= DAC2_ATTEN_RST;
    end else if (reg_wr && reg_addr == ADDR_DAC2_ATTEN) begin
      dac2_atten_reg <= reg_wdata & WRITABLE_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      adc_mix_reg <= ADC_MIX_RST;
    end else if (regs_locked) begin
      adc_mix_reg <= ADC_MIX_RST;
    end else if (reg_wr && reg_addr == ADDR_ADC_MIX) begin
      adc_mix_reg <= reg_wdata & WRITABLE_MASK;
    end
  end

  // ---------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] rdata_next;

  // Unmapped addresses read zero; data stands only the cycle after the strobe.
  always_comb begin
    case (reg_addr)
      ADDR_CONV_CTRL:  rdata_next = {conv_dis_reg, {(DATA_W-1){1'b0}}};
      ADDR_DAC2_ATTEN: rdata_next = regs_locked ? DAC2_ATTEN_RST : dac2_atten_reg;
      ADDR_ADC_MIX:    rdata_next = regs_locked ? ADC_MIX_RST : adc_mix_reg;
      default:         rdata_next = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ---------------------------------------------------------------------
  // DAC2 output attenuation
  // ---------------------------------------------------------------------
  // All-ones on DAC2 is 94.5 dB of loss, not a mute, so no code mute here.
  atten_stage #(.W(W)) u_dac2_left (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .sample_in      (dac2_left_in),
    .atten          (dac2_atten_reg[LEFT_ATTEN_LSB +: ATTEN_W]),
    .mute           (dac2_atten_reg[LEFT_MUTE_BIT]),
    .full_mute_code (1'b0),
    .sample_out     (dac2_left_out)
  );

  atten_stage #(.W(W)) u_dac2_right (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .sample_in      (dac2_right_in),
    .atten          (dac2_atten_reg[RIGHT_ATTEN_LSB +: ATTEN_W]),
    .mute           (dac2_atten_reg[RIGHT_MUTE_BIT]),
    .full_mute_code (1'b0),
    .sample_out     (dac2_right_out)
  );

  // ---------------------------------------------------------------------
  // ADC mix into DAC1 input path
  // ---------------------------------------------------------------------
  logic signed [W-1:0] mix_left;
  logic signed [W-1:0] mix_right;
  logic signed [W-1:0] dac1_left_dly_reg;
  logic signed [W-1:0] dac1_right_dly_reg;

  // Mix code all-ones is a full mute, unlike DAC2.
  atten_stage #(.W(W)) u_mix_left (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .sample_in      (adc_left),
    .atten          (adc_mix_reg[LEFT_ATTEN_LSB +: ATTEN_W]),
    .mute           (adc_mix_reg[LEFT_MUTE_BIT]),
    .full_mute_code (1'b1),
    .sample_out     (mix_left)
  );

  atten_stage #(.W(W)) u_mix_right (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .sample_in      (adc_right),
    .atten          (adc_mix_reg[RIGHT_ATTEN_LSB +: ATTEN_W]),
    .mute           (adc_mix_reg[RIGHT_MUTE_BIT]),
    .full_mute_code (1'b1),
    .sample_out     (mix_right)
  );

  // Delay the direct path one cycle to line up with the registered mix.
  // Samples are assumed held for many cycles, as sample rates are far below
  // the system clock; this is why no rate-matching buffer is present.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dac1_left_dly_reg  <= '0;
      dac1_right_dly_reg <= '0;
    end else begin
      dac1_left_dly_reg  <= dac1_left_in;
      dac1_right_dly_reg <= dac1_right_in;
    end
  end

  // Left feeds left and right feeds right, never crossed.
  sat_adder #(.W(W)) u_sum_left (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .a       (dac1_left_dly_reg),
    .b       (mix_left),
    .sum     (dac1_left_out)
  );

  sat_adder #(.W(W)) u_sum_right (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .a       (dac1_right_dly_reg),
    .b       (mix_right),
    .sum     (dac1_right_out)
  );

endmodule : dac_atten_adc_mix_regs

//--- tb/regs_checker_properties.sv
// Port checker for the attenuation and mix register bank.
`timescale 1ns/100ps
module regs_checker
  import atten_mix_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  input wire logic                sys_clk,
  input wire logic                nrst,
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [DATA_W-1:0]   reg_rdata,
  input wire logic signed [W-1:0] dac2_left_in,
  input wire logic signed [W-1:0] dac2_left_out,
  input wire logic signed [W-1:0] dac1_left_in,
  input wire logic signed [W-1:0] dac1_left_out,
  input wire logic                all_conversions_disable,
  input wire logic                regs_locked
);
  logic [15:0] dac2_reg;
  logic [15:0] mix_reg;
  logic [15:0] dac2_exp;
  logic [15:0] mix_exp;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Shadow copies; a lock wins over a write in the same cycle.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dac2_reg <= DAC2_ATTEN_RST;
      mix_reg  <= ADC_MIX_RST;
    end else if (regs_locked) begin
      dac2_reg <= DAC2_ATTEN_RST;
      mix_reg  <= ADC_MIX_RST;
    end else if (reg_wr && reg_addr == ADDR_DAC2_ATTEN) begin
      dac2_reg <= reg_wdata & WRITABLE_MASK;
    end else if (reg_wr && reg_addr == ADDR_ADC_MIX) begin
      mix_reg  <= reg_wdata & WRITABLE_MASK;
    end
  end
  // Effective values: a locked register acts as its default.
  assign dac2_exp = regs_locked ? DAC2_ATTEN_RST : dac2_reg;
  assign mix_exp  = regs_locked ? ADC_MIX_RST : mix_reg;
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_read_dac2: assert property (reg_rd && reg_addr == ADDR_DAC2_ATTEN
    |=> reg_rdata == $past(dac2_exp)) else $error("dac2 register read wrong");
  a_read_mix: assert property (reg_rd && reg_addr == ADDR_ADC_MIX
    |=> reg_rdata == $past(mix_exp)) else $error("mix register read wrong");
  a_disable_lock: assert property (all_conversions_disable |-> regs_locked)
    else $error("disable bit set but registers not locked");
  // The data path follows the stored value, which clears one cycle after a lock.
  a_dac2_mute: assert property (dac2_reg[15] |=> dac2_left_out == 16'sh0000)
    else $error("muted dac2 channel not silent");
  a_dac2_unity: assert property (dac2_reg[15:8] == 8'h00
    |=> dac2_left_out == $past(dac2_left_in)) else $error("dac2 at 0 dB not unity");
  a_mix_mute: assert property (mix_reg[15]
    |-> ##2 dac1_left_out == $past(dac1_left_in, 2)) else $error("muted mix leaks");
  a_mix_code: assert property (mix_reg[13:8] == ATTEN_FULL_MUTE
    |-> ##2 dac1_left_out == $past(dac1_left_in, 2)) else $error("full mute code leaks");
endmodule : regs_checker
bind dac_atten_adc_mix_regs regs_checker #(.W(W)) regs_checker_inst (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .dac2_left_in(dac2_left_in), .dac2_left_out(dac2_left_out),
  .dac1_left_in(dac1_left_in), .dac1_left_out(dac1_left_out),
  .all_conversions_disable(all_conversions_disable), .regs_locked(regs_locked));

//--- tb/host_model.sv
// Host model that drives the register bus as the controlling processor would.
`timescale 1ns/100ps
module host_model
  import atten_mix_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic [DATA_W-1:0] reg_rdata,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd
);
  // Idle bus; both converters share one rate clock and the link outruns it.
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // Write cycle; reserved bits go out as zero with the strobe and as one in the cycle after it.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d & WRITABLE_MASK;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~(d & WRITABLE_MASK);
  endtask : wr
  // Read cycle; data is taken in the one cycle where it stands.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    // Taken at the edge that closes the data cycle, before it returns to zero.
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : rd
endmodule : host_model

//--- tb/tb_top.sv
// Self-checking bench for the attenuation and mix register bank.
`timescale 1ns/100ps
module tb_top
  import atten_mix_pkg::*;
;
  logic sys_clk = 0, nrst = 0, power_down_pin_n = 0, reg_wr, reg_rd;
  logic all_conversions_disable, regs_locked;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic signed [15:0] d2l = 0, d2r = 0, d2lo, d2ro, al = 0, ar = 0;
  logic signed [15:0] d1l = 0, d1r = 0, d1lo, d1ro;
  int num_errors = 0, checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  host_model host_model_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  dac_atten_adc_mix_regs dac_atten_adc_mix_regs_inst (.sys_clk(sys_clk), .nrst(nrst),
    .power_down_pin_n(power_down_pin_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac2_left_in(d2l),
    .dac2_right_in(d2r), .dac2_left_out(d2lo), .dac2_right_out(d2ro), .adc_left(al),
    .adc_right(ar), .dac1_left_in(d1l), .dac1_right_in(d1r), .dac1_left_out(d1lo),
    .dac1_right_out(d1ro), .all_conversions_disable(all_conversions_disable),
    .regs_locked(regs_locked));
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task rd_chk(input string n, input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host_model_inst.rd(a, d);
    chk(n, d, exp);
  endtask : rd_chk
  task final_report;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // Defaults after reset and an unmapped read.
  task reset_defaults;
    rd_chk("dac2 reset", ADDR_DAC2_ATTEN, 16'h0000);
    rd_chk("mix reset", ADDR_ADC_MIX, 16'h8080);
    rd_chk("unmapped", 5'h01, 16'h0000);
  endtask : reset_defaults
  // Writes of all fields, one idle cycle apart, read back.
  task map_rw;
    host_model_inst.wr(ADDR_DAC2_ATTEN, 16'hbfbf);
    host_model_inst.wr(ADDR_ADC_MIX, 16'h1f01);
    rd_chk("dac2 map", ADDR_DAC2_ATTEN, 16'hbfbf);
    rd_chk("mix map", ADDR_ADC_MIX, 16'h1f01);
  endtask : map_rw
  // DAC2 mute and attenuation steps on fixed samples.
  task dac2_gain;
    logic [15:0] c [4] = '{16'h0000, 16'h8080, 16'h0404, 16'h0808};
    int e [4] = '{1000, 0, 500, 250};
    for (int i = 0; i < 4; i++) begin
      host_model_inst.wr(ADDR_DAC2_ATTEN, c[i]);
      repeat (4) @(posedge sys_clk);
      chk("dac2 left", d2lo, 16'(e[i]));
      chk("dac2 right", d2ro, 16'(-e[i]));
    end
  endtask : dac2_gain
  // ADC mix into the DAC1 path: 0 dB, mute, 6 dB, full mute code.
  task mix_gain;
    logic [15:0] c [4] = '{16'h0000, 16'h8080, 16'h0404, 16'h3f3f};
    int el [4] = '{300, 200, 250, 200};
    int er [4] = '{-40, 10, -15, 10};
    for (int i = 0; i < 4; i++) begin
      host_model_inst.wr(ADDR_ADC_MIX, c[i]);
      repeat (4) @(posedge sys_clk);
      chk("dac1 left", d1lo, 16'(el[i]));
      chk("dac1 right", d1ro, 16'(er[i]));
    end
  endtask : mix_gain
  // Disable bit locks; writes during the lock never land.
  task disable_lock;
    host_model_inst.wr(ADDR_CONV_CTRL, 16'h8000);
    repeat (2) @(posedge sys_clk);
    chk("disable", {15'h0, all_conversions_disable}, 16'h0001);
    rd_chk("conv ctrl", ADDR_CONV_CTRL, 16'h8000);
    rd_chk("mix locked", ADDR_ADC_MIX, 16'h8080);
    host_model_inst.wr(ADDR_DAC2_ATTEN, 16'h1234);
    host_model_inst.wr(ADDR_CONV_CTRL, 16'h0000);
    rd_chk("dac2 dropped", ADDR_DAC2_ATTEN, 16'h0000);
    rd_chk("mix cleared", ADDR_ADC_MIX, 16'h8080);
  endtask : disable_lock
  // Power-down pin clears and locks; release keeps the defaults.
  task power_lock;
    host_model_inst.wr(ADDR_DAC2_ATTEN, 16'h0404);
    power_down_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("locked", {15'h0, regs_locked}, 16'h0001);
    host_model_inst.wr(ADDR_DAC2_ATTEN, 16'h1111);
    rd_chk("dac2 pd", ADDR_DAC2_ATTEN, 16'h0000);
    power_down_pin_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_chk("dac2 after pd", ADDR_DAC2_ATTEN, 16'h0000);
  endtask : power_lock
  // Main sequence; the watchdog cuts a hang short.
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    power_down_pin_n <= 1'b1;
    d2l <= 1000;
    d2r <= -1000;
    al <= 100;
    ar <= -50;
    d1l <= 200;
    d1r <= 10;
    repeat (4) @(posedge sys_clk);
    reset_defaults();
    map_rw();
    dac2_gain();
    mix_gain();
    disable_lock();
    power_lock();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end
endmodule : tb_top
